// ===== dsg_pkg.sv
// Package: register map, field layout and carrier types for the deep-sleep clock gate bank
package dsg_pkg;

    localparam int DSG_NUM_UNITS = 8;
    localparam int DSG_ADDR_W = 12;

    // Block base in the system map; the port below decodes offsets only
    localparam logic [31:0] DSG_SYSCTL_BASE = 32'h400f_e000;

    // Register offsets (bytes)
    localparam logic [11:0] DSG_OFS_RUN_CLOCK_CONFIG = 12'h060;
    localparam logic [11:0] DSG_OFS_RUN_GATE = 12'h104;
    localparam logic [11:0] DSG_OFS_SLEEP_GATE = 12'h114;
    localparam logic [11:0] DSG_OFS_DEEP_GATE = 12'h124;
    localparam logic [11:0] DSG_OFS_IRQ_STATUS = 12'h200;
    localparam logic [11:0] DSG_OFS_IRQ_MASK = 12'h204;
    localparam logic [11:0] DSG_OFS_ACTIVE_GATE = 12'h208;

    // Gating register layout
    localparam logic [31:0] DSG_GATE_RESET = 32'h0000_0000;
    localparam logic [31:0] DSG_GATE_WR_MASK = 32'h0007_5013;
    localparam int DSG_POS_ASYNC_SERIAL0 = 0;
    localparam int DSG_POS_ASYNC_SERIAL1 = 1;
    localparam int DSG_POS_SYNC_SERIAL0 = 4;
    localparam int DSG_POS_TWO_WIRE0 = 12;
    localparam int DSG_POS_TWO_WIRE1 = 14;
    localparam int DSG_POS_GP_COUNTER0 = 16;
    localparam int DSG_POS_GP_COUNTER1 = 17;
    localparam int DSG_POS_GP_COUNTER2 = 18;

    // Unit index -> bit position in a gating register
    localparam int DSG_UNIT_POS [DSG_NUM_UNITS] = '{
        DSG_POS_ASYNC_SERIAL0, DSG_POS_ASYNC_SERIAL1, DSG_POS_SYNC_SERIAL0, DSG_POS_TWO_WIRE0,
        DSG_POS_TWO_WIRE1, DSG_POS_GP_COUNTER0, DSG_POS_GP_COUNTER1, DSG_POS_GP_COUNTER2
    };

    // Run clock configuration register
    localparam int DSG_CFG_AUTO_BIT = 0;
    localparam logic DSG_CFG_AUTO_RESET = 1'b0;

    // Interrupt registers
    localparam logic [7:0] DSG_IRQ_RESET = 8'h00;

    typedef struct packed {
        logic valid;
        logic write;
        logic [2:0] unit;
    } dsg_acc_t;

    typedef enum {
        DSG_MODE_RUN,
        DSG_MODE_SLEEP,
        DSG_MODE_DEEP
    } dsg_mode_t;

endpackage

// ===== dsg_gate_reg.sv
// One 32-bit unit clock gating register with read-only reserved bits
`timescale 1ns/100ps
`default_nettype none
module dsg_gate_reg
    import dsg_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Write port
    input wire logic i_we,
    input wire logic [31:0] i_wdata,
    // Stored value
    output logic [31:0] o_q
);
    logic [31:0] gate_q;
    logic [31:0] gate_d;

    // Reserved bits never store, so they read zero
    assign gate_d = i_we ? (i_wdata & DSG_GATE_WR_MASK) : gate_q;

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            gate_q <= DSG_GATE_RESET;
        else
            gate_q <= gate_d;
    end

    assign o_q = gate_q;
endmodule // dsg_gate_reg
`default_nettype wire

// ===== dsg_unit_clk_gate.sv
// Glitch-free clock gate for one peripheral unit
`timescale 1ns/100ps
`default_nettype none
module dsg_unit_clk_gate (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Enable, already registered on the rising edge
    input wire logic i_en,
    // Gated clock
    output logic o_gclk
);
    logic en_low_q;

    // Enable changes only while the clock is low, so no runt pulse escapes
    always_ff @(negedge i_clk)
    begin
        if (!i_rst_n)
            en_low_q <= 1'b0;
        else
            en_low_q <= i_en;
    end

    assign o_gclk = i_clk & en_low_q;
endmodule // dsg_unit_clk_gate
`default_nettype wire

// ===== dsg_gate_bank.sv
// Deep-sleep clock gate bank: gating registers, mode select, unit clocks and fault answers
`timescale 1ns/100ps
`default_nettype none

// How it works
// - A set gating bit enables the clock of its unit so that the unit runs.
// - A clear gating bit stops the unit's clock and holds the unit disabled.
// - An access to a unit whose clock is off is answered with a bus fault.
// - After reset every gating bit is zero, so no unit is clocked.
// - Three gating registers of equal layout serve run, sleep and deep-sleep.
// - Sleep and deep-sleep registers govern only with auto gating on, else run governs.
// - Counters sit at bits 18..16, two-wire at 14 and 12, sync serial at 4, async serial at 1 and 0.
// - The deep-sleep register decodes at offset 0x124 and is 32 bits wide.
// - Bits that control no unit are read-only and have no effect.
module dsg_gate_bank
    import dsg_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Register port
    input wire logic [dsg_pkg::DSG_ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_we,
    input wire logic i_re,
    output logic [31:0] o_rdata,
    // Power state
    input wire logic i_sleep,
    input wire logic i_deep_sleep,
    // Peripheral access check
    input wire dsg_pkg::dsg_acc_t i_acc,
    output logic o_acc_done,
    output logic o_acc_fault,
    // Units
    output logic [dsg_pkg::DSG_NUM_UNITS-1:0] o_unit_clk,
    output logic [dsg_pkg::DSG_NUM_UNITS-1:0] o_unit_en,
    // Interrupt
    output logic o_irq
);
    import dsg_pkg::*;

    localparam int NU = DSG_NUM_UNITS;

    // Address decode
    wire hit_cfg = (i_addr == DSG_OFS_RUN_CLOCK_CONFIG);
    wire hit_run = (i_addr == DSG_OFS_RUN_GATE);
    wire hit_sleep = (i_addr == DSG_OFS_SLEEP_GATE);
    wire hit_deep = (i_addr == DSG_OFS_DEEP_GATE);
    wire hit_ist = (i_addr == DSG_OFS_IRQ_STATUS);
    wire hit_imask = (i_addr == DSG_OFS_IRQ_MASK);
    wire hit_active = (i_addr == DSG_OFS_ACTIVE_GATE);

    wire we_cfg = i_we & hit_cfg;
    wire we_ist = i_we & hit_ist;
    wire we_imask = i_we & hit_imask;

    // Three gating registers, same layout
    logic [2:0] gate_we;
    logic [31:0] gate_q [3];

    assign gate_we[0] = i_we & hit_run;
    assign gate_we[1] = i_we & hit_sleep;
    assign gate_we[2] = i_we & hit_deep;

    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_gate_reg
            dsg_gate_reg u_reg (
                .i_clk(i_clk),
                .i_rst_n(i_rst_n),
                .i_we(gate_we[g]),
                .i_wdata(i_wdata),
                .o_q(gate_q[g])
            );
        end
    endgenerate

    // Auto low-power gating enable
    logic auto_gate_q;
    logic auto_gate_d;

    assign auto_gate_d = we_cfg ? i_wdata[DSG_CFG_AUTO_BIT] : auto_gate_q;

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            auto_gate_q <= DSG_CFG_AUTO_RESET;
        else
            auto_gate_q <= auto_gate_d;
    end

    // Which register governs the unit clocks now
    dsg_mode_t mode;

    always_comb
    begin
        mode = DSG_MODE_RUN;
        if (auto_gate_q && i_deep_sleep)
            mode = DSG_MODE_DEEP;
        else if (auto_gate_q && i_sleep)
            mode = DSG_MODE_SLEEP;
    end

    logic [31:0] sel_gate;

    always_comb
    begin
        case (mode)
            DSG_MODE_RUN: sel_gate = gate_q[0];
            DSG_MODE_SLEEP: sel_gate = gate_q[1];
            DSG_MODE_DEEP: sel_gate = gate_q[2];
            default: sel_gate = gate_q[0];
        endcase
    end

    // Pick the unit bits out of the governing register
    logic [NU-1:0] sel_unit;
    logic [NU-1:0] en_q;

    genvar u;
    generate
        for (u = 0; u < NU; u++)
        begin : g_unit
            assign sel_unit[u] = sel_gate[DSG_UNIT_POS[u]];

            dsg_unit_clk_gate u_cg (
                .i_clk(i_clk),
                .i_rst_n(i_rst_n),
                .i_en(en_q[u]),
                .o_gclk(o_unit_clk[u])
            );
        end
    endgenerate

    // Registered enables; the unit is held disabled while its bit is clear
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            en_q <= '0;
        else
            en_q <= sel_unit;
    end

    assign o_unit_en = en_q;

    // Active enables placed back into register layout for readback
    logic [31:0] active_word;

    always_comb
    begin
        active_word = '0;
        for (int k = 0; k < NU; k++)
            active_word[DSG_UNIT_POS[k]] = en_q[k];
    end

    // Access check: the unit's live enable decides the answer
    wire acc_gated = ~en_q[i_acc.unit];
    wire acc_fault_evt = i_acc.valid & acc_gated;
    // Software must have enabled the unit first, or every access faults
    wire acc_ok_evt = i_acc.valid & ~acc_gated;

    logic acc_done_q;
    logic acc_fault_q;

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            acc_done_q <= 1'b0;
            acc_fault_q <= 1'b0;
        end
        else
        begin
            acc_done_q <= acc_ok_evt;
            acc_fault_q <= acc_fault_evt;
        end
    end

    assign o_acc_done = acc_done_q;
    assign o_acc_fault = acc_fault_q;

    // Fault status per unit, write one to clear; a new fault wins over the clear
    logic [NU-1:0] fault_vec;
    logic [NU-1:0] ist_q;
    logic [NU-1:0] ist_d;
    logic [NU-1:0] imask_q;
    logic [NU-1:0] imask_d;

    always_comb
    begin
        fault_vec = '0;
        fault_vec[i_acc.unit] = acc_fault_evt;
    end

    assign ist_d = (ist_q & ~(we_ist ? i_wdata[NU-1:0] : '0)) | fault_vec;
    assign imask_d = we_imask ? i_wdata[NU-1:0] : imask_q;

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            ist_q <= DSG_IRQ_RESET;
            imask_q <= DSG_IRQ_RESET;
        end
        else
        begin
            ist_q <= ist_d;
            imask_q <= imask_d;
        end
    end

    assign o_irq = |(ist_q & imask_q);

    // Read mux; unmapped offsets and reserved bits read zero
    logic [31:0] rd_mux;

    always_comb
    begin
        rd_mux = '0;
        if (hit_cfg)
            rd_mux[DSG_CFG_AUTO_BIT] = auto_gate_q;
        else if (hit_run)
            rd_mux = gate_q[0];
        else if (hit_sleep)
            rd_mux = gate_q[1];
        else if (hit_deep)
            rd_mux = gate_q[2];
        else if (hit_ist)
            rd_mux[NU-1:0] = ist_q;
        else if (hit_imask)
            rd_mux[NU-1:0] = imask_q;
        else if (hit_active)
            rd_mux = active_word;
    end

    logic [31:0] rdata_q;

    // Data stand only in the cycle after the read strobe
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            rdata_q <= '0;
        else if (i_re)
            rdata_q <= rd_mux;
        else
            rdata_q <= '0;
    end

    assign o_rdata = rdata_q;

endmodule // dsg_gate_bank
`default_nettype wire

// ===== dsg_gate_bank_properties.sv
// Port assertions for the deep-sleep clock gate bank
`timescale 1ns/100ps
`default_nettype none
module dsg_gate_bank_properties
    import dsg_pkg::*;
(
    // All top ports, observed only
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [dsg_pkg::DSG_ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_we,
    input wire logic i_re,
    input wire logic [31:0] o_rdata,
    input wire logic i_sleep,
    input wire logic i_deep_sleep,
    input wire dsg_pkg::dsg_acc_t i_acc,
    input wire logic o_acc_done,
    input wire logic o_acc_fault,
    input wire logic [dsg_pkg::DSG_NUM_UNITS-1:0] o_unit_clk,
    input wire logic [dsg_pkg::DSG_NUM_UNITS-1:0] o_unit_en,
    input wire logic o_irq
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    wire deep_sel = i_addr == DSG_OFS_DEEP_GATE;
    // Shadow of the deep-sleep register; reserved bits never stick
    logic [31:0] deep_model_q;
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            deep_model_q <= DSG_GATE_RESET;
        else if (i_we && deep_sel)
            deep_model_q <= i_wdata & DSG_GATE_WR_MASK;
    end
    AST_FAULT: assert property (i_acc.valid && !o_unit_en[i_acc.unit] |=> o_acc_fault && !o_acc_done)
        else $error("gated unit access not faulted");
    AST_DONE: assert property (i_acc.valid && o_unit_en[i_acc.unit] |=> o_acc_done && !o_acc_fault)
        else $error("clocked unit access not completed");
    AST_RSV: assert property (i_re && deep_sel |=> (o_rdata & ~DSG_GATE_WR_MASK) == 32'h0)
        else $error("reserved bits read nonzero");
    AST_WR_RD: assert property (i_re && deep_sel |=> o_rdata == $past(deep_model_q))
        else $error("deep gate readback wrong");
    AST_RST: assert property ($rose(i_rst_n) |-> o_unit_en == '0 && o_rdata == 32'h0 && !o_irq)
        else $error("outputs not cleared by reset");
    AST_UCLK: assert property (@(negedge i_clk) disable iff (!i_rst_n) o_unit_clk == $past(o_unit_en))
        else $error("unit clock does not follow enable");
    AST_STABLE: assert property (!i_we ##1 ($stable(i_sleep) && $stable(i_deep_sleep)) |=> $stable(o_unit_en))
        else $error("enable moved without cause");
    AST_MASK: assert property (i_we && i_addr == DSG_OFS_IRQ_MASK && i_wdata[7:0] == 8'h00 |=> !o_irq)
        else $error("interrupt high while fully masked");
    C_FAULT: cover property (o_acc_fault);
    C_DONE: cover property (o_acc_done);
    C_DEEP: cover property (i_deep_sleep && o_unit_en != '0);
endmodule // dsg_gate_bank_properties
bind dsg_gate_bank dsg_gate_bank_properties u_dsg_gate_bank_properties (.i_clk, .i_rst_n, .i_addr, .i_wdata,
    .i_we, .i_re, .o_rdata, .i_sleep, .i_deep_sleep, .i_acc, .o_acc_done, .o_acc_fault, .o_unit_clk,
    .o_unit_en, .o_irq);
`default_nettype wire

// ===== dsg_periph_model.sv
// Gated peripheral model: notes clock activity per unit
`timescale 1ns/100ps
`default_nettype none
module dsg_periph_model
    import dsg_pkg::*;
(
    // Control
    input wire logic i_clr,
    // Gated unit clocks
    input wire logic [dsg_pkg::DSG_NUM_UNITS-1:0] i_unit_clk,
    // Unit saw a clock edge since clear
    output logic [dsg_pkg::DSG_NUM_UNITS-1:0] o_ticked
);
    logic tick_q [DSG_NUM_UNITS];
    for (genvar g = 0; g < DSG_NUM_UNITS; g++)
    begin : g_unit
        // A unit only advances on its own clock
        always @(posedge i_unit_clk[g] or posedge i_clr)
        begin
            if (i_clr)
                tick_q[g] <= 1'b0;
            else
                tick_q[g] <= 1'b1;
        end
        assign o_ticked[g] = tick_q[g];
    end
endmodule // dsg_periph_model
`default_nettype wire

// ===== test_deep_sleep_clock_gate_bank.sv
// Self-checking bench for the deep-sleep clock gate bank
`timescale 1ns/100ps
`default_nettype none
module test_deep_sleep_clock_gate_bank;
    import dsg_pkg::*;
    logic i_clk, i_rst_n, i_we, i_re, i_sleep, i_deep_sleep, o_acc_done, o_acc_fault, o_irq, clr, auto;
    logic [DSG_ADDR_W-1:0] i_addr;
    logic [31:0] i_wdata, o_rdata, rd;
    logic [31:0] rv [3];
    logic [7:0] o_unit_clk, o_unit_en, ticked, en, mask, flt;
    dsg_acc_t i_acc;
    int num_errors = 0, n_tests = 0, seed = 80, cyc = 0;
    localparam logic [11:0] OFS [3] = '{DSG_OFS_RUN_GATE, DSG_OFS_SLEEP_GATE, DSG_OFS_DEEP_GATE};
    dsg_gate_bank u_dsg_gate_bank (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_we, .i_re, .o_rdata, .i_sleep,
        .i_deep_sleep, .i_acc, .o_acc_done, .o_acc_fault, .o_unit_clk, .o_unit_en, .o_irq);
    dsg_periph_model u_dsg_periph_model (.i_clr(clr), .i_unit_clk(o_unit_clk), .o_ticked(ticked));
    initial
    begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            summarize();
        end
    end
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_we <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_we <= 1'b0;
    endtask
    task automatic rdreg(input logic [11:0] a);
        @(posedge i_clk);
        i_re <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_re <= 1'b0;
        #1;
        rd = o_rdata;
    endtask
    task automatic acc(input int u);
        @(posedge i_clk);
        i_acc <= {1'b1, 1'($random(seed)), 3'(u)};
        @(posedge i_clk);
        i_acc <= '0;
        #1;
        chk("fault", 32'(o_acc_fault), 32'(!en[u]));
        chk("done", 32'(o_acc_done), 32'(en[u]));
        flt[u] = !en[u];
    endtask
    // Governing register picked by mode, mapped to unit order
    function automatic logic [7:0] exp_en(input logic [31:0] r0, r1, r2, input logic a, s, d);
        logic [31:0] gr;
        logic [7:0] e;
        gr = (a && d) ? r2 : (a && s) ? r1 : r0;
        for (int k = 0; k < DSG_NUM_UNITS; k++)
            e[k] = gr[DSG_UNIT_POS[k]];
        return e;
    endfunction
    initial
    begin
        i_rst_n = 1'b0;
        i_we = 1'b0;
        i_re = 1'b0;
        i_addr = '0;
        i_wdata = '0;
        i_sleep = 1'b0;
        i_deep_sleep = 1'b0;
        i_acc = '0;
        clr = 1'b0;
        repeat (3) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rdreg(DSG_OFS_DEEP_GATE);
        chk("deep reset", rd, DSG_GATE_RESET);
        chk("en reset", 32'(o_unit_en), 32'h0);
        rdreg(12'h7fc);
        chk("unmapped", rd, 32'h0);
        // First two passes: all ones then zero, deep-sleep with auto gating
        for (int i = 0; i < 14; i++)
        begin
            for (int r = 0; r < 3; r++)
                rv[r] = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : $random(seed);
            auto = (i < 2) || 1'($random(seed));
            // Second pass faults every unit with the interrupt fully masked
            mask = (i == 1) ? 8'h00 : 8'($random(seed));
            for (int r = 0; r < 3; r++)
                wr(OFS[r], rv[r]);
            wr(DSG_OFS_RUN_CLOCK_CONFIG, 32'(auto));
            wr(DSG_OFS_IRQ_MASK, 32'(mask));
            wr(DSG_OFS_IRQ_STATUS, 32'h0000_00ff);
            i_sleep <= 1'($random(seed));
            i_deep_sleep <= (i < 2) || 1'($random(seed));
            for (int r = 0; r < 3; r++)
            begin
                rdreg(OFS[r]);
                chk("gate reg", rd, rv[r] & DSG_GATE_WR_MASK);
            end
            en = exp_en(rv[0], rv[1], rv[2], auto, i_sleep, i_deep_sleep);
            chk("unit en", 32'(o_unit_en), 32'(en));
            chk("irq clear", 32'(o_irq), 32'h0);
            @(posedge i_clk);
            clr <= 1'b1;
            @(posedge i_clk);
            clr <= 1'b0;
            repeat (3) @(posedge i_clk);
            chk("unit clocks", 32'(ticked), 32'(en));
            flt = 8'h00;
            for (int u = 0; u < DSG_NUM_UNITS; u++)
                acc(u);
            chk("irq", 32'(o_irq), 32'(|(flt & mask)));
            $display("test %0d done", i);
        end
        // Corner: a fault beside a clear of its own status bit keeps the bit set
        wr(DSG_OFS_RUN_GATE, 32'h0);
        wr(DSG_OFS_RUN_CLOCK_CONFIG, 32'h0);
        @(posedge i_clk);
        i_we <= 1'b1;
        i_addr <= DSG_OFS_IRQ_STATUS;
        i_wdata <= 32'h0000_00ff;
        i_acc <= {1'b1, 1'b0, 3'd5};
        @(posedge i_clk);
        i_we <= 1'b0;
        i_acc <= '0;
        rdreg(DSG_OFS_IRQ_STATUS);
        chk("set wins", rd, 32'h0000_0020);
        $display("test set-wins done");
        // Corner: reset in mid-run with loaded registers and a pending status bit
        wr(DSG_OFS_DEEP_GATE, 32'hffff_ffff);
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rdreg(DSG_OFS_DEEP_GATE);
        chk("deep after reset", rd, DSG_GATE_RESET);
        chk("en after reset", 32'(o_unit_en), 32'h0);
        rdreg(DSG_OFS_IRQ_STATUS);
        chk("status after reset", rd, 32'h0);
        chk("irq after reset", 32'(o_irq), 32'h0);
        $display("test mid-run reset done");
        summarize();
    end
endmodule // test_deep_sleep_clock_gate_bank
`default_nettype wire
